// [hdl/psq_pkg.sv]
package psq_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS = 40;
  localparam int TOPO_TIMEOUT_NS = 120000;
  // a timeout is a longest time: round down
  localparam int TOPO_CYC = TOPO_TIMEOUT_NS / CLK_NS;
  localparam int AUTO_WAKE_NS = 1000000;
  // a least wait: round up
  localparam int AUTO_WAKE_CYC = (AUTO_WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PRE_SOFT_CYC = 2500;
  localparam int SUP_SOFT_CYC = 2500;
  localparam int ANA_TEST_CYC = 16;
  localparam int CNT_W = 24;

  // ****************************************
  // register map (byte offsets)
  // ****************************************
  localparam logic [11:0] OFF_CMD = 12'h000;
  localparam logic [11:0] OFF_INIT_LOCK = 12'h004;
  localparam logic [11:0] OFF_INIT_CFG = 12'h008;
  localparam logic [11:0] OFF_WAKE_EN = 12'h00C;
  localparam logic [11:0] OFF_SAFE_CTRL = 12'h010;
  localparam logic [11:0] OFF_STATUS = 12'h014;
  localparam logic [11:0] OFF_WAKE_SRC = 12'h018;
  localparam int CMD_SLEEP_BIT = 0;
  localparam int CMD_AUTO_BIT = 1;
  localparam int CMD_KEY_LSB = 8;
  localparam logic [7:0] SECURE_KEY = 8'hA5;
  localparam logic [7:0] INIT_CFG_RST = 8'h00;
  localparam logic [2:0] WAKE_EN_RST = 3'h7;

  // ****************************************
  // synchronised pin vector
  // ****************************************
  localparam int PIN_GATE = 0;
  localparam int PIN_UV = 1;
  localparam int PIN_KEY = 2;
  localparam int PIN_WAKE = 3;
  localparam int PIN_SEL = 6;
  localparam int PIN_MON = 9;
  localparam int PIN_RST_FB = 14;
  localparam int PIN_SAFE_FB = 15;
  localparam int NPINS = 16;

  typedef enum logic [3:0] {
    M_TOPO, M_PRE_ON, M_SELECT, M_SUP_ON, M_INIT, M_NORMAL,
    M_DEEP_FS, M_OFF_SLEEP, M_OFF_AUTO, M_OFF_DEEP
  } psq_main_t;

  typedef enum logic [2:0] {
    S_LOGIC_TEST, S_SEL_WAIT, S_ANA_TEST, S_REL_WAIT, S_INIT, S_NORMAL
  } psq_safe_t;

  typedef struct packed {
    logic pre_regulator;
    logic core_supply;
    logic aux_supply;
    logic analog_ref_supply;
    logic transceiver_supply;
    logic keep_alive_supply;
  } psq_sup_t;

  typedef struct packed {
    logic deep_fs_en;
    logic analog_5v;
    logic aux_5v;
  } psq_sel_t;

  typedef struct packed {
    logic timer;
    logic io;
    logic bus;
  } psq_wake_t;
endpackage

// [hdl/psq_sequencer.sv]
// Notes on behaviour
// - main power machine and safety machine run side by side.
// - topology detection runs at every start-up before the pre-regulator.
// - gate pin above 120 mV before timeout locks buck-boost, else buck.
// - pre-regulator switches on with soft start after topology detection.
// - select phase decodes supply levels and deep fail-safe enable.
// - core, aux, analog supplies and transceiver supply start together.
// - init phase follows reset release; some registers writable only there.
// - any write to init-lock locks init registers and enters normal.
// - sleep only from normal by secured command; ignored elsewhere.
// - in off modes only keep-alive stays on; wake enables all.
// - sleep wakes on enabled sources, records source, restarts both machines.
// - auto-wake off on undervoltage or secured command; restart after 1.0 ms.
// - entering auto-wake off restarts the safety machine from scratch.
// - deep off entered from deep fail-safe with key low; left on rising key.
// - off modes keep main registers, clear all safety registers.
// - logic self-test runs at every start-up and wake-up.
// - logic test failure keeps safe outputs low, flags, still releases reset.
// - safety machine sets supervisor thresholds and deep fail-safe from select.
// - analog test failure blocks safe outputs but not reset release.
// - first analog test checks supervisor comparators and reset, safe feedback.
// - primary safe output low after start, released only on controller request.
//
// Added by the designer: the register addresses and the APB register port.
module psq_sequencer
  import psq_pkg::*;
#(
  parameter int AW = 12,
  parameter int PRE_SOFT = PRE_SOFT_CYC,
  parameter int SUP_SOFT = SUP_SOFT_CYC,
  parameter int AUTO_WAKE = AUTO_WAKE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic low_side_gate_pin,
  input wire logic prereg_undervoltage,
  input wire logic key_in,
  input wire logic [2:0] wake_pins,
  input wire logic [2:0] select_pins,
  input wire logic [4:0] supervisor_flags,
  input wire logic mcu_reset_fb,
  input wire logic primary_safe_fb,
  input wire logic deep_fs_req,
  input wire logic logic_self_test_done,
  input wire logic logic_self_test_pass,
  output logic gate_probe_en,
  output psq_sup_t supplies,
  output logic buck_boost,
  output psq_sel_t threshold_sel,
  output logic logic_self_test_start,
  output logic analog_self_test_force,
  output logic mcu_reset_out,
  output logic primary_safe_out,
  output logic secondary_safe_out,
  output logic [7:0] init_cfg
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [NPINS-1:0] pin_raw;
  logic [NPINS-1:0] pin_f;
  assign pin_raw = {primary_safe_fb, mcu_reset_fb, supervisor_flags, select_pins,
                    wake_pins, key_in, prereg_undervoltage, low_side_gate_pin};

  // a change counts only once stages two and three agree
  for (genvar i = 0; i < NPINS; i++) begin : g_sync
    logic s1;
    logic s2;
    logic s3;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
        pin_f[i] <= 1'b0;
      end else begin
        s1 <= pin_raw[i];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
          pin_f[i] <= s3;
        end
      end
    end
  end

  logic gate_det;
  logic uv;
  logic key;
  psq_wake_t wake_now;
  psq_sel_t sel_now;
  logic [4:0] mon;
  assign gate_det = pin_f[PIN_GATE];
  assign uv = pin_f[PIN_UV];
  assign key = pin_f[PIN_KEY];
  assign wake_now = pin_f[PIN_WAKE+2:PIN_WAKE];
  assign sel_now = pin_f[PIN_SEL+2:PIN_SEL];
  assign mon = pin_f[PIN_MON+4:PIN_MON];

  // ****************************************
  // apb slave
  // ****************************************
  psq_main_t m_state;
  psq_safe_t s_state;
  psq_sel_t sel_cfg;
  psq_wake_t wake_en;
  psq_wake_t wake_src;
  logic [1:0] safe_rel;
  logic logic_fail;
  logic analog_fail;
  logic [11:0] addr;
  logic acc_wr;
  logic cmd_ok;
  logic wr_sleep;
  logic wr_auto;
  logic wr_lock;
  logic in_cfg_mode;
  logic [31:0] rd_data;
  logic rd_err;

  assign addr = 12'(paddr);
  assign acc_wr = psel & penable & pready & pwrite;
  assign cmd_ok = acc_wr && addr == OFF_CMD && pwdata[CMD_KEY_LSB+:8] == SECURE_KEY;
  assign wr_sleep = cmd_ok & pwdata[CMD_SLEEP_BIT];
  assign wr_auto = cmd_ok & pwdata[CMD_AUTO_BIT];
  assign wr_lock = acc_wr && addr == OFF_INIT_LOCK;
  assign in_cfg_mode = m_state == M_INIT || m_state == M_NORMAL;

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    case (addr)
      OFF_CMD, OFF_INIT_LOCK: rd_data = 32'h0000_0000;
      OFF_INIT_CFG: rd_data = {24'h00_0000, init_cfg};
      OFF_WAKE_EN: rd_data = {29'h0000_0000, wake_en};
      OFF_SAFE_CTRL: rd_data = {30'h0000_0000, safe_rel};
      OFF_STATUS: rd_data = {18'h0_0000, sel_cfg, analog_fail, logic_fail,
                             buck_boost, mcu_reset_out, s_state, m_state};
      OFF_WAKE_SRC: rd_data = {29'h0000_0000, wake_src};
      default: rd_err = 1'b1;
    endcase
  end

  // answer is prepared in the setup cycle, so every access ends in one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr <= rd_err;
      end
    end
  end

  // ****************************************
  // main-machine registers (kept through off modes)
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_cfg <= INIT_CFG_RST;
    end else if (acc_wr && addr == OFF_INIT_CFG && m_state == M_INIT) begin
      init_cfg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_en <= WAKE_EN_RST;
    end else if (acc_wr && addr == OFF_WAKE_EN && in_cfg_mode) begin
      wake_en <= pwdata[2:0];
    end
  end

  // write one to clear; a wake in the same cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_src <= 3'h0;
    end else begin
      if (acc_wr && addr == OFF_WAKE_SRC) begin
        wake_src <= wake_src & ~pwdata[2:0];
      end
      if (m_state == M_OFF_SLEEP && |(wake_now & wake_en)) begin
        wake_src <= wake_now & wake_en;
      end
    end
  end

  // ****************************************
  // main power machine
  // ****************************************
  logic [CNT_W-1:0] m_cnt;
  logic key_q;
  logic sup_done;
  logic m_off;
  assign m_off = m_state == M_OFF_SLEEP || m_state == M_OFF_AUTO || m_state == M_OFF_DEEP;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m_state <= M_TOPO;
      m_cnt <= '0;
      buck_boost <= 1'b0;
      sel_cfg <= '0;
      sup_done <= 1'b0;
      key_q <= 1'b0;
    end else begin
      key_q <= key;
      m_cnt <= m_cnt + 1'b1;
      case (m_state)
        M_TOPO: begin
          sup_done <= 1'b0;
          if (gate_det) begin
            buck_boost <= 1'b1;
            m_state <= M_PRE_ON;
            m_cnt <= '0;
          end else if (m_cnt == CNT_W'(TOPO_CYC - 1)) begin
            buck_boost <= 1'b0;
            m_state <= M_PRE_ON;
            m_cnt <= '0;
          end
        end
        M_PRE_ON: begin
          if (m_cnt == CNT_W'(PRE_SOFT - 1)) begin
            m_state <= M_SELECT;
          end
        end
        M_SELECT: begin
          sel_cfg <= sel_now;
          m_state <= M_SUP_ON;
          m_cnt <= '0;
        end
        M_SUP_ON: begin
          if (m_cnt >= CNT_W'(SUP_SOFT - 1)) begin
            sup_done <= 1'b1;
            m_cnt <= m_cnt;
          end
          if (mcu_reset_out) begin
            m_state <= M_INIT;
          end
        end
        M_INIT: begin
          if (deep_fs_req && sel_cfg.deep_fs_en) begin
            m_state <= M_DEEP_FS;
          end else if (uv) begin
            m_state <= M_OFF_AUTO;
            m_cnt <= '0;
          end else if (wr_lock) begin
            m_state <= M_NORMAL;
          end
        end
        M_NORMAL: begin
          if (deep_fs_req && sel_cfg.deep_fs_en) begin
            m_state <= M_DEEP_FS;
          end else if (uv || wr_auto) begin
            m_state <= M_OFF_AUTO;
            m_cnt <= '0;
          end else if (wr_sleep) begin
            m_state <= M_OFF_SLEEP;
          end
        end
        M_DEEP_FS: begin
          if (!key) begin
            m_state <= M_OFF_DEEP;
          end
        end
        M_OFF_SLEEP: begin
          if (|(wake_now & wake_en)) begin
            m_state <= M_TOPO;
            m_cnt <= '0;
          end
        end
        M_OFF_AUTO: begin
          if (m_cnt == CNT_W'(AUTO_WAKE - 1)) begin
            m_state <= M_TOPO;
            m_cnt <= '0;
          end
        end
        M_OFF_DEEP: begin
          if (key && !key_q) begin
            m_state <= M_TOPO;
            m_cnt <= '0;
          end
        end
        default: begin
          m_state <= M_TOPO;
          m_cnt <= '0;
        end
      endcase
    end
  end

  // ****************************************
  // supply enables
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supplies <= '0;
      gate_probe_en <= 1'b0;
    end else begin
      gate_probe_en <= m_state == M_TOPO;
      supplies.keep_alive_supply <= 1'b1;
      supplies.pre_regulator <= m_state inside {M_PRE_ON, M_SELECT, M_SUP_ON,
                                                M_INIT, M_NORMAL};
      // the four later supplies share one enable so they start together
      supplies.core_supply <= m_state inside {M_SUP_ON, M_INIT, M_NORMAL};
      supplies.aux_supply <= m_state inside {M_SUP_ON, M_INIT, M_NORMAL};
      supplies.analog_ref_supply <= m_state inside {M_SUP_ON, M_INIT, M_NORMAL};
      supplies.transceiver_supply <= m_state inside {M_SUP_ON, M_INIT, M_NORMAL};
    end
  end

  // ****************************************
  // safety machine
  // ****************************************
  logic [4:0] s_cnt;
  logic s_restart;
  // deep fail-safe and every off mode wipe the safety side
  assign s_restart = m_off || m_state == M_DEEP_FS;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_state <= S_LOGIC_TEST;
      s_cnt <= '0;
      logic_fail <= 1'b0;
      analog_fail <= 1'b0;
      safe_rel <= 2'b00;
      threshold_sel <= '0;
      mcu_reset_out <= 1'b0;
      logic_self_test_start <= 1'b0;
      analog_self_test_force <= 1'b0;
    end else if (s_restart) begin
      s_state <= S_LOGIC_TEST;
      s_cnt <= '0;
      logic_fail <= 1'b0;
      analog_fail <= 1'b0;
      safe_rel <= 2'b00;
      threshold_sel <= '0;
      mcu_reset_out <= 1'b0;
      logic_self_test_start <= 1'b0;
      analog_self_test_force <= 1'b0;
    end else begin
      if (acc_wr && addr == OFF_SAFE_CTRL && in_cfg_mode) begin
        safe_rel <= pwdata[1:0];
      end
      case (s_state)
        S_LOGIC_TEST: begin
          logic_self_test_start <= 1'b1;
          if (logic_self_test_start && logic_self_test_done) begin
            logic_fail <= ~logic_self_test_pass;
            logic_self_test_start <= 1'b0;
            s_state <= S_SEL_WAIT;
          end
        end
        S_SEL_WAIT: begin
          if (m_state == M_SUP_ON) begin
            threshold_sel <= sel_cfg;
            s_state <= S_ANA_TEST;
            s_cnt <= '0;
          end
        end
        S_ANA_TEST: begin
          analog_self_test_force <= 1'b1;
          s_cnt <= s_cnt + 1'b1;
          if (s_cnt == 5'(ANA_TEST_CYC - 1)) begin
            // forced comparators must trip; held-low pins must read back low
            analog_fail <= ~(&mon) | pin_f[PIN_RST_FB] | pin_f[PIN_SAFE_FB];
            analog_self_test_force <= 1'b0;
            s_state <= S_REL_WAIT;
          end
        end
        S_REL_WAIT: begin
          // test failures do not hold the reset back
          if (sup_done) begin
            mcu_reset_out <= 1'b1;
            s_state <= S_INIT;
          end
        end
        S_INIT: begin
          if (m_state == M_NORMAL) begin
            s_state <= S_NORMAL;
          end
        end
        S_NORMAL: begin
        end
        default: begin
          s_state <= S_LOGIC_TEST;
        end
      endcase
    end
  end

  // ****************************************
  // safe outputs
  // ****************************************
  logic safe_ok;
  assign safe_ok = (s_state == S_INIT || s_state == S_NORMAL) && !s_restart
                   && !logic_fail && !analog_fail;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_safe_out <= 1'b0;
      secondary_safe_out <= 1'b0;
    end else begin
      primary_safe_out <= safe_ok & safe_rel[0];
      secondary_safe_out <= safe_ok & safe_rel[1];
    end
  end

endmodule // psq_sequencer

// [tb/psq_env_model.sv]
// ****
// self-test responders and pin readback
// ****
module psq_env_model
  import psq_pkg::*;
#(
  parameter int DLY = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic logic_self_test_start,
  input wire logic analog_self_test_force,
  input wire logic mcu_reset_out,
  input wire logic primary_safe_out,
  input wire logic logic_test_bad,
  input wire logic analog_test_bad,
  output logic logic_self_test_done,
  output logic logic_self_test_pass,
  output logic [4:0] supervisor_flags,
  output logic mcu_reset_fb,
  output logic primary_safe_fb
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // answer held until start drops, so the sequencer cannot miss it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      logic_self_test_done <= 1'b0;
      logic_self_test_pass <= 1'b0;
    end else if (!logic_self_test_start) begin
      cnt <= 0;
      logic_self_test_done <= 1'b0;
      logic_self_test_pass <= 1'b0;
    end else if (cnt == DLY) begin
      logic_self_test_done <= 1'b1;
      logic_self_test_pass <= !logic_test_bad;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // comparators trip only while forced; a broken one stays quiet
  assign supervisor_flags = (analog_self_test_force && !analog_test_bad) ? 5'h1F : 5'h00;
  // pulled-up pins read back what the device drives
  assign mcu_reset_fb = mcu_reset_out;
  assign primary_safe_fb = primary_safe_out;
endmodule // psq_env_model

// [tb/psq_sequencer_monitor.sv]
module psq_sequencer_monitor
  import psq_pkg::*;
#(
  parameter int AW = 12,
  parameter int PRE_SOFT = PRE_SOFT_CYC,
  parameter int SUP_SOFT = SUP_SOFT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [4:0] supervisor_flags,
  input wire logic logic_self_test_done,
  input wire logic logic_self_test_pass,
  input wire logic gate_probe_en,
  input wire psq_sup_t supplies,
  input wire logic buck_boost,
  input wire logic logic_self_test_start,
  input wire logic analog_self_test_force,
  input wire logic mcu_reset_out,
  input wire logic primary_safe_out,
  input wire logic secondary_safe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic lb_fail;
  logic ana_fail;
  logic [7:0] ana_cnt;
  logic wr_safe;
  assign wr_safe = psel && penable && pready && pwrite && paddr == OFF_SAFE_CTRL && pwdata[0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lb_fail <= 1'b0;
      ana_fail <= 1'b0;
    end else if (logic_self_test_start && !logic_self_test_done) begin
      lb_fail <= 1'b0;
      ana_fail <= 1'b0;
    end else begin
      if (logic_self_test_start && !logic_self_test_pass) lb_fail <= 1'b1;
      if (analog_self_test_force && supervisor_flags != 5'h1F) ana_fail <= 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ana_cnt <= 8'h00;
    else if (analog_self_test_force) ana_cnt <= ana_cnt + 8'h01;
    else ana_cnt <= 8'h00;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_TOPO_FIRST: assert property (
    $rose(supplies.pre_regulator) |-> $past(gate_probe_en) || $past(gate_probe_en, 2))
    else $error("pre-regulator started without topology probe");
  AST_TOPO_LOCK: assert property (
    supplies.pre_regulator && $past(supplies.pre_regulator) |-> $stable(buck_boost))
    else $error("topology changed while converter runs");
  AST_PRE_SOFT: assert property (
    $rose(supplies.core_supply) |-> $past(supplies.pre_regulator, PRE_SOFT))
    else $error("core supply before pre-regulator soft start");
  AST_SUP_TOGETHER: assert property (
    supplies.core_supply == supplies.aux_supply &&
    supplies.aux_supply == supplies.analog_ref_supply &&
    supplies.aux_supply == supplies.transceiver_supply)
    else $error("supplies not switched together");
  AST_KEEP_ALIVE: assert property (
    $past(presetn) |-> supplies.keep_alive_supply &&
    (supplies.pre_regulator || !supplies.core_supply))
    else $error("keep-alive off or supply on without pre-regulator");
  AST_RST_AFTER: assert property (
    $rose(mcu_reset_out) |-> $past(supplies.core_supply, SUP_SOFT) &&
    !analog_self_test_force && !logic_self_test_start)
    else $error("reset released too early");
  AST_SAFE_REQ: assert property (
    $rose(primary_safe_out) |-> $past(wr_safe) || $past(wr_safe, 2))
    else $error("safe output released without request");
  AST_ANA_LEN: assert property (
    // force is registered, so it lags entry to the test state by one cycle
    $fell(analog_self_test_force) |-> ana_cnt == 8'(ANA_TEST_CYC - 1))
    else $error("analog test force length wrong");
  AST_TEST_FAIL: assert property (
    lb_fail || ana_fail |-> !primary_safe_out && !secondary_safe_out)
    else $error("safe output high after self-test failure");
  COV_SAFE: cover property ($rose(primary_safe_out));
  COV_FAIL_RST: cover property (lb_fail && mcu_reset_out);
  COV_RESTART: cover property ($fell(supplies.pre_regulator));
endmodule // psq_sequencer_monitor
bind psq_sequencer psq_sequencer_monitor #(.AW(AW), .PRE_SOFT(PRE_SOFT), .SUP_SOFT(SUP_SOFT))
  i_mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .supervisor_flags, .logic_self_test_done, .logic_self_test_pass, .gate_probe_en,
  .supplies, .buck_boost, .logic_self_test_start, .analog_self_test_force,
  .mcu_reset_out, .primary_safe_out, .secondary_safe_out);

// [tb/psq_sequencer_tb.sv]
module psq_sequencer_tb
  import psq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // short counts keep the run small
  localparam int AW_CYC = 20;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, rd_err;
  logic low_side_gate_pin, prereg_undervoltage, key_in, mcu_reset_fb, primary_safe_fb;
  logic deep_fs_req, logic_self_test_done, logic_self_test_pass, gate_probe_en, buck_boost;
  logic logic_self_test_start, analog_self_test_force, mcu_reset_out;
  logic primary_safe_out, secondary_safe_out, logic_test_bad, analog_test_bad;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_data;
  logic [2:0] wake_pins, select_pins;
  logic [4:0] supervisor_flags;
  logic [7:0] init_cfg;
  psq_sup_t supplies;
  psq_sel_t threshold_sel;
  int err_count = 0;
  int total_checks = 0;
  int cyc = 0;
  psq_sequencer #(.PRE_SOFT(8), .SUP_SOFT(8), .AUTO_WAKE(AW_CYC)) i_dut (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .low_side_gate_pin,
    .prereg_undervoltage, .key_in, .wake_pins, .select_pins, .supervisor_flags, .mcu_reset_fb,
    .primary_safe_fb, .deep_fs_req, .logic_self_test_done, .logic_self_test_pass,
    .gate_probe_en, .supplies, .buck_boost, .threshold_sel, .logic_self_test_start,
    .analog_self_test_force, .mcu_reset_out, .primary_safe_out, .secondary_safe_out, .init_cfg);
  psq_env_model i_env (.pclk, .presetn, .logic_self_test_start, .analog_self_test_force,
    .mcu_reset_out, .primary_safe_out, .logic_test_bad, .analog_test_bad, .logic_self_test_done,
    .logic_self_test_pass, .supervisor_flags, .mcu_reset_fb, .primary_safe_fb);
  always #20 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // ****
  // bus cycles
  // ****
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_data = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic st(input psq_main_t m);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk({28'h0, rd_data[3:0]}, {28'h0, m});
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_boot(input logic bb);
    while (mcu_reset_out !== 1'b1) @(posedge pclk);
    chk({31'h0, buck_boost}, {31'h0, bb});
    chk({26'h0, supplies}, 32'h3F);
    chk({29'h0, threshold_sel}, 32'h4);
    chk({30'h0, primary_safe_out, secondary_safe_out}, 32'h0);
    st(M_INIT);
  endtask
  task automatic t_init();
    apb(1'b1, OFF_INIT_CFG, 32'h5A);
    apb(1'b0, OFF_INIT_CFG, 32'h0);
    chk(rd_data, 32'h5A);
    chk({24'h0, init_cfg}, 32'h5A);
    apb(1'b1, OFF_CMD, {16'h0, SECURE_KEY, 8'h01});
    repeat (4) @(posedge pclk);
    st(M_INIT);
    apb(1'b1, OFF_INIT_LOCK, 32'h0);
    st(M_NORMAL);
    apb(1'b1, OFF_INIT_CFG, 32'hC3);
    apb(1'b0, OFF_INIT_CFG, 32'h0);
    chk(rd_data, 32'h5A);
    apb(1'b0, 12'h0FC, 32'h0);
    chk({31'h0, rd_err}, 32'h1);
  endtask
  task automatic t_safe(input logic ok);
    apb(1'b1, OFF_SAFE_CTRL, 32'h3);
    repeat (2) @(posedge pclk);
    chk({30'h0, primary_safe_out, secondary_safe_out}, {30'h0, ok, ok});
    chk({31'h0, mcu_reset_out}, 32'h1);
  endtask
  task automatic t_sleep();
    apb(1'b1, OFF_CMD, {16'h0, 8'h5A, 8'h01});
    repeat (4) @(posedge pclk);
    st(M_NORMAL);
    apb(1'b1, OFF_WAKE_EN, 32'h2);
    low_side_gate_pin <= 1'b0;
    apb(1'b1, OFF_CMD, {16'h0, SECURE_KEY, 8'h01});
    repeat (4) @(posedge pclk);
    st(M_OFF_SLEEP);
    chk({26'h0, supplies}, 32'h01);
    wake_pins <= 3'b001;
    repeat (12) @(posedge pclk);
    st(M_OFF_SLEEP);
    wake_pins <= 3'b010;
    repeat (12) @(posedge pclk);
    wake_pins <= 3'b000;
    t_boot(1'b0);
    apb(1'b0, OFF_WAKE_SRC, 32'h0);
    chk(rd_data, 32'h2);
    apb(1'b1, OFF_WAKE_SRC, 32'h2);
    apb(1'b0, OFF_WAKE_SRC, 32'h0);
    chk(rd_data, 32'h0);
    apb(1'b0, OFF_INIT_CFG, 32'h0);
    chk(rd_data, 32'h5A);
    apb(1'b0, OFF_SAFE_CTRL, 32'h0);
    chk(rd_data, 32'h0);
    apb(1'b1, OFF_INIT_LOCK, 32'h0);
  endtask
  task automatic t_auto();
    int n;
    n = 0;
    low_side_gate_pin <= 1'b1;
    apb(1'b1, OFF_SAFE_CTRL, 32'h3);
    apb(1'b1, OFF_CMD, {16'h0, SECURE_KEY, 8'h02});
    while (supplies.pre_regulator !== 1'b0) @(posedge pclk);
    while (supplies.pre_regulator !== 1'b1) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, (n >= AW_CYC && n < AW_CYC + 40)}, 32'h1);
    t_boot(1'b1);
    apb(1'b0, OFF_SAFE_CTRL, 32'h0);
    chk(rd_data, 32'h0);
    apb(1'b1, OFF_INIT_LOCK, 32'h0);
  endtask
  task automatic t_fail(input logic lb, input logic ab);
    logic_test_bad <= lb;
    analog_test_bad <= ab;
    prereg_undervoltage <= 1'b1;
    while (supplies.pre_regulator !== 1'b0) @(posedge pclk);
    prereg_undervoltage <= 1'b0;
    t_boot(1'b1);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk({30'h0, rd_data[10:9]}, {30'h0, ab, lb});
    apb(1'b1, OFF_INIT_LOCK, 32'h0);
    t_safe(!(lb || ab));
    logic_test_bad <= 1'b0;
    analog_test_bad <= 1'b0;
  endtask
  task automatic t_deep();
    deep_fs_req <= 1'b1;
    repeat (4) @(posedge pclk);
    deep_fs_req <= 1'b0;
    repeat (8) @(posedge pclk);
    st(M_DEEP_FS);
    key_in <= 1'b0;
    repeat (12) @(posedge pclk);
    st(M_OFF_DEEP);
    chk({26'h0, supplies}, 32'h01);
    key_in <= 1'b1;
    t_boot(1'b1);
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    low_side_gate_pin = 1'b1;
    prereg_undervoltage = 1'b0;
    key_in = 1'b1;
    wake_pins = 3'b000;
    select_pins = 3'b100;
    deep_fs_req = 1'b0;
    logic_test_bad = 1'b0;
    analog_test_bad = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_boot(1'b1);
    t_init();
    t_safe(1'b1);
    t_sleep();
    t_auto();
    t_fail(1'b1, 1'b0);
    t_fail(1'b0, 1'b1);
    t_deep();
    finish_test();
  end
endmodule // psq_sequencer_tb
